// ===== rtl/dma_channel.v
// One DMA channel: register slave, request select, address update and bus sequencer
// Summary of operation
// (RULE1) Window code n of 1..27 lets only low n address bits change, up to 128 Mbytes.
// (RULE2) Code zero updates the full address; code one wraps bit 0 only.
// (RULE3) Request select is an 8-bit RW vector number; zero selects no source.
// (RULE4) Normal, repeat and block modes per channel, with either addressing mode.
// (RULE5) Repeat or block size is 1 to 65,536 units of the access size.
// (RULE6) Total count up to 4 Gbytes; zero count means unlimited, counter held.
// (RULE7) Auto request offers cycle stealing or burst bus use.
// (RULE8) Triggers: software auto request, peripheral interrupt, external request.
// (RULE9) Offset addition and window wrap are available in every mode.
// (RULE10) Single address mode moves each unit in one bus cycle with the acknowledge strobe.
// (RULE11) Dual address mode reads from source register, writes to destination register.
// (RULE12) Narrow bus or misaligned address splits an access into several bus cycles; the code splits only dual mode accesses, single mode always uses one cycle.
// (RULE13) Dual mode reads first, then writes the captured data.
// (RULE14) Read and write of one dual transfer are locked together on the bus.
// (RULE15) End strobe is gated by its enable bit in the mode register.
// (RULE16) Dual mode end strobe covers the idle cycle and both bus cycles.
// (RULE17) Dual mode never asserts the acknowledge strobe.
// (RULE18) Window overflow wraps to start when incrementing, end when decrementing.
// (RULE19) Address bits above the window stay fixed.
// (RULE20) Destination wrap with its enable clears transfer enable and sets end status.
// (RULE21) Acknowledge strobe is active low.
// (RULE22) Peripheral request counts only when its vector matches the selected one.
//
// The register addresses and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module dma_channel (
	input wire clk_i, // System clock, 200 MHz
	input wire rst_n_i, // Asynchronous reset, active low
	input wire [7:0] s_axi_awaddr_i, // Write address
	input wire s_axi_awvalid_i, // Write address valid
	output wire s_axi_awready_o, // Write address ready
	input wire [31:0] s_axi_wdata_i, // Write data
	input wire [3:0] s_axi_wstrb_i, // Write byte enables
	input wire s_axi_wvalid_i, // Write data valid
	output wire s_axi_wready_o, // Write data ready
	output reg [1:0] s_axi_bresp_o, // Write response
	output reg s_axi_bvalid_o, // Write response valid
	input wire s_axi_bready_i, // Write response ready
	input wire [7:0] s_axi_araddr_i, // Read address
	input wire s_axi_arvalid_i, // Read address valid
	output wire s_axi_arready_o, // Read address ready
	output reg [31:0] s_axi_rdata_o, // Read data
	output reg [1:0] s_axi_rresp_o, // Read response
	output reg s_axi_rvalid_o, // Read data valid
	input wire s_axi_rready_i, // Read data ready
	input wire periph_irq_valid_i, // Peripheral interrupt pulse
	input wire [7:0] periph_irq_vector_i, // Its vector number
	input wire ext_req_n_i, // External request, active low
	output wire bus_req_o, // System bus request
	input wire bus_gnt_i, // System bus grant
	output wire bus_lock_o, // Keep the bus across read and write
	output wire bus_cyc_o, // Bus cycle valid
	input wire bus_ack_i, // Bus cycle done
	output wire bus_we_o, // Bus write
	output wire [31:0] bus_addr_o, // Bus byte address
	output wire [2:0] bus_bytes_o, // Bytes in this cycle
	output wire [31:0] bus_wdata_o, // Write data, low lanes
	input wire [31:0] bus_rdata_i, // Read data, low lanes
	output wire ack_strobe_n_o, // External acknowledge, active low
	output wire transfer_end_strobe_n_o // End of transfer, active low
);
`include "dma_channel_consts.vh"
	localparam [2:0] S_IDLE = 3'd0;
	localparam [2:0] S_GAP = 3'd1;
	localparam [2:0] S_RD = 3'd2;
	localparam [2:0] S_WR = 3'd3;
	localparam [2:0] S_SGL = 3'd4;
	localparam [2:0] S_STEP = 3'd5;

	// Byte-enable merge of a bus write
	function [31:0] merge;
		input [31:0] old;
		input [31:0] nw;
		input [3:0] be;
		integer i;
		begin
			merge = old;
			for (i = 0; i < 4; i = i + 1)
				if (be[i])
					merge[i*8 +: 8] = nw[i*8 +: 8];
		end
	endfunction

	// Bytes per bus cycle: byte pieces when misaligned, else the smaller of size and width
	function [2:0] piece;
		input [2:0] size;
		input [2:0] width;
		input [31:0] a;
		begin
			if ((a[2:0] & (size - 3'd1)) != 3'd0)
				piece = 3'd1;
			else if (width < size)
				piece = width;
			else
				piece = size;
		end
	endfunction

	// Step value of one address side
	function [31:0] step;
		input [1:0] kind;
		input [2:0] size;
		input [31:0] offs;
		begin
			case (kind)
				`STEP_INC: step = {29'd0, size};
				`STEP_DEC: step = 32'd0 - {29'd0, size};
				`STEP_OFFS: step = offs;
				default: step = 32'd0;
			endcase
		end
	endfunction

	reg [31:0] src_r, dst_r, src_start_r, dst_start_r, cnt_r, offs_r, mode_r;
	reg [15:0] bsz_r;
	reg [16:0] blk_r;
	reg [7:0] sel_r;
	reg end_status_flag_r;
	reg [2:0] state_r;
	reg [2:0] off_r;
	reg [31:0] data_r;
	reg aw_full_r, w_full_r;
	reg [7:0] aw_addr_r;
	reg [31:0] w_data_r;
	reg [3:0] w_strb_r;
	wire req;
	wire [31:0] src_nxt, dst_nxt;
	wire src_wrap, dst_wrap;

	wire [2:0] size_b = 3'd1 << mode_r[`MD_SIZE];
	wire [2:0] busw_b = 3'd1 << mode_r[`MD_BUSW];
	wire dual = !mode_r[`MD_SINGLE];
	wire [1:0] xmode = mode_r[`MD_XMODE];
	wire [16:0] bsz_units = (bsz_r == 16'h0000) ? 17'h1_0000 : {1'b0, bsz_r}; // RULE5
	wire [16:0] blk_inc = blk_r + 17'd1;
	wire blk_end = blk_inc == bsz_units;
	wire cnt_limited = cnt_r != 32'h0000_0000; // RULE6
	wire cnt_end = cnt_limited && cnt_r <= {29'd0, size_b};
	wire is_last = (xmode == `XM_BLOCK) ? (blk_end || cnt_end) : cnt_end;
	wire [31:0] cur_a = (state_r == S_WR) ? dst_r : src_r;
	wire [31:0] sgl_a = mode_r[`MD_DIRS] ? dst_r : src_r;
	wire [31:0] addr_now = (state_r == S_SGL) ? sgl_a : cur_a + {29'd0, off_r};
	// Alignment is judged on the access start, so an aligned longword splits into even pieces
	wire [2:0] pb = (state_r == S_SGL) ? size_b : piece(size_b, busw_b, cur_a); // RULE12
	wire [3:0] off_sum = {1'b0, off_r} + {1'b0, pb};
	wire [31:0] rd_mask = (pb == 3'd4) ? 32'hFFFF_FFFF : ((pb == 3'd2) ? 32'h0000_FFFF : 32'h0000_00FF);
	wire take = state_r == S_IDLE && req && mode_r[`MD_EN];
	wire wr_fire = aw_full_r && w_full_r && !s_axi_bvalid_o;

	// Address update of each side, with offset and window wrap
	window_addr_step u_src_step (
		.addr_i(src_r),
		.delta_i(step(mode_r[`MD_SSTEP], size_b, offs_r)),
		.win_i(mode_r[`MD_SWIN]),
		.next_o(src_nxt),
		.wrap_o(src_wrap)
	); // RULE9

	window_addr_step u_dst_step (
		.addr_i(dst_r),
		.delta_i(step(mode_r[`MD_DSTEP], size_b, offs_r)),
		.win_i(mode_r[`MD_DWIN]),
		.next_o(dst_nxt),
		.wrap_o(dst_wrap)
	); // RULE9

	// Trigger selection
	request_source u_req (
		.clk_i(clk_i),
		.rst_n_i(rst_n_i),
		.trig_i(mode_r[`MD_TRIG]),
		.enable_i(mode_r[`MD_EN]),
		.select_i(sel_r),
		.periph_valid_i(periph_irq_valid_i),
		.periph_vector_i(periph_irq_vector_i),
		.ext_req_n_i(ext_req_n_i),
		.take_i(take),
		.req_o(req)
	);

	// Slave handshakes
	assign s_axi_awready_o = !aw_full_r;
	assign s_axi_wready_o = !w_full_r;
	assign s_axi_arready_o = !s_axi_rvalid_o;

	// Bus master outputs
	assign bus_req_o = state_r != S_IDLE;
	assign bus_lock_o = state_r == S_RD || state_r == S_WR; // RULE14
	assign bus_cyc_o = state_r == S_RD || state_r == S_WR || state_r == S_SGL;
	assign bus_we_o = state_r == S_WR || (state_r == S_SGL && mode_r[`MD_DIRS]);
	assign bus_addr_o = addr_now; // RULE11
	assign bus_bytes_o = pb;
	assign bus_wdata_o = data_r >> {off_r, 3'b000};
	assign ack_strobe_n_o = !(state_r == S_SGL); // RULE10 RULE17 RULE21
	// Block index and count move only in STEP, so is_last always describes the unit in flight
	assign transfer_end_strobe_n_o = !(mode_r[`MD_END_STROBE_ENABLE] && is_last && state_r != S_IDLE
		&& state_r != S_STEP); // RULE15 RULE16

	// Write address and data captured in either order
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			aw_full_r <= 1'b0;
			w_full_r <= 1'b0;
			aw_addr_r <= 8'h00;
			w_data_r <= `RST_WORD;
			w_strb_r <= 4'h0;
			s_axi_bvalid_o <= 1'b0;
			s_axi_bresp_o <= `RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid_i && !aw_full_r)
			begin
				aw_full_r <= 1'b1;
				aw_addr_r <= s_axi_awaddr_i;
			end
			if (s_axi_wvalid_i && !w_full_r)
			begin
				w_full_r <= 1'b1;
				w_data_r <= s_axi_wdata_i;
				w_strb_r <= s_axi_wstrb_i;
			end
			if (wr_fire)
			begin
				aw_full_r <= 1'b0;
				w_full_r <= 1'b0;
				s_axi_bvalid_o <= 1'b1;
				case (aw_addr_r)
					`OFS_SRC, `OFS_DST, `OFS_CNT, `OFS_BSZ, `OFS_OFFS, `OFS_MODE, `OFS_REQSEL,
					`OFS_STAT: s_axi_bresp_o <= `RESP_OKAY;
					default: s_axi_bresp_o <= `RESP_SLVERR;
				endcase
			end
			else if (s_axi_bvalid_o && s_axi_bready_i)
				s_axi_bvalid_o <= 1'b0;
		end
	end

	// Read channel, answer one cycle after the address is taken
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			s_axi_rvalid_o <= 1'b0;
			s_axi_rdata_o <= `RST_WORD;
			s_axi_rresp_o <= `RESP_OKAY;
		end
		else if (s_axi_arvalid_i && !s_axi_rvalid_o)
		begin
			s_axi_rvalid_o <= 1'b1;
			s_axi_rresp_o <= `RESP_OKAY;
			case (s_axi_araddr_i)
				`OFS_SRC: s_axi_rdata_o <= src_r;
				`OFS_DST: s_axi_rdata_o <= dst_r;
				`OFS_CNT: s_axi_rdata_o <= cnt_r;
				`OFS_BSZ: s_axi_rdata_o <= {16'h0000, bsz_r};
				`OFS_OFFS: s_axi_rdata_o <= offs_r;
				`OFS_MODE: s_axi_rdata_o <= mode_r;
				`OFS_REQSEL: s_axi_rdata_o <= {24'h00_0000, sel_r}; // RULE3
				`OFS_STAT: s_axi_rdata_o <= {30'd0, state_r != S_IDLE, end_status_flag_r};
				default:
				begin
					s_axi_rdata_o <= `RST_WORD;
					s_axi_rresp_o <= `RESP_SLVERR;
				end
			endcase
		end
		else if (s_axi_rvalid_o && s_axi_rready_i)
			s_axi_rvalid_o <= 1'b0;
	end

	// Registers and transfer sequencer; hardware updates follow software writes
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			src_r <= `RST_WORD;
			dst_r <= `RST_WORD;
			src_start_r <= `RST_WORD;
			dst_start_r <= `RST_WORD;
			cnt_r <= `RST_WORD;
			offs_r <= `RST_WORD;
			mode_r <= `RST_WORD;
			bsz_r <= `RST_BSZ;
			sel_r <= `RST_SEL;
			end_status_flag_r <= 1'b0;
			blk_r <= 17'd0;
			state_r <= S_IDLE;
			off_r <= 3'd0;
			data_r <= `RST_WORD;
		end
		else
		begin
			if (wr_fire)
			begin
				case (aw_addr_r)
					`OFS_SRC:
					begin
						src_r <= merge(src_r, w_data_r, w_strb_r);
						src_start_r <= merge(src_r, w_data_r, w_strb_r);
					end
					`OFS_DST:
					begin
						dst_r <= merge(dst_r, w_data_r, w_strb_r);
						dst_start_r <= merge(dst_r, w_data_r, w_strb_r);
					end
					`OFS_CNT: cnt_r <= merge(cnt_r, w_data_r, w_strb_r);
					`OFS_BSZ: bsz_r <= w_strb_r[1:0] == 2'b11 ? w_data_r[15:0] : bsz_r;
					`OFS_OFFS: offs_r <= merge(offs_r, w_data_r, w_strb_r);
					`OFS_MODE: mode_r <= merge(mode_r, w_data_r, w_strb_r) & `MODE_MASK; // RULE4
					`OFS_REQSEL: sel_r <= w_strb_r[0] ? w_data_r[7:0] : sel_r; // RULE3
					`OFS_STAT: end_status_flag_r <= end_status_flag_r & !(w_strb_r[0] && w_data_r[`ST_END_STATUS_FLAG]);
					default: ;
				endcase
				if (aw_addr_r == `OFS_MODE && !w_data_r[`MD_EN])
					blk_r <= 17'd0;
			end
			case (state_r)
				S_IDLE:
					if (take)
					begin
						state_r <= S_GAP;
					end
				S_GAP:
					if (bus_gnt_i)
					begin
						state_r <= dual ? S_RD : S_SGL;
						off_r <= 3'd0;
						data_r <= `RST_WORD;
					end
				S_RD:
					if (bus_ack_i)
					begin
						data_r <= data_r | ((bus_rdata_i & rd_mask) << {off_r, 3'b000}); // RULE13
						if (off_sum >= {1'b0, size_b})
						begin
							state_r <= S_WR;
							off_r <= 3'd0;
						end
						else
							off_r <= off_sum[2:0];
					end
				S_WR:
					if (bus_ack_i)
					begin
						if (off_sum >= {1'b0, size_b})
							state_r <= S_STEP;
						else
							off_r <= off_sum[2:0];
					end
				S_SGL:
					if (bus_ack_i)
						state_r <= S_STEP;
				S_STEP:
				begin
					src_r <= src_nxt;
					dst_r <= dst_nxt;
					if (cnt_limited)
						cnt_r <= cnt_r - {29'd0, size_b}; // RULE6
					blk_r <= blk_end ? 17'd0 : blk_inc;
					// Repeat or block area returns to its start address
					if (blk_end && xmode != `XM_NORMAL && mode_r[`MD_AREA_EN])
					begin
						if (mode_r[`MD_ARS])
							dst_r <= dst_start_r;
						else
							src_r <= src_start_r;
					end
					if (dst_wrap && mode_r[`MD_DWIE]) // RULE20
					begin
						mode_r[`MD_EN] <= 1'b0;
						end_status_flag_r <= 1'b1;
						state_r <= S_IDLE;
					end
					else if (cnt_end)
					begin
						mode_r[`MD_EN] <= 1'b0;
						state_r <= S_IDLE;
					end
					else if (xmode == `XM_BLOCK && !blk_end)
					begin
						state_r <= S_GAP;
					end
					else if (mode_r[`MD_TRIG] == `TRIG_AUTO && mode_r[`MD_BURST] && mode_r[`MD_EN]) // RULE7
					begin
						state_r <= S_GAP;
					end
					else
						state_r <= S_IDLE; // RULE7
				end
				default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // dma_channel

// ===== pkg/dma_channel_consts.vh
// Register offsets, field positions and codes of the DMA channel
`ifndef DMA_CHANNEL_CONSTS_VH
`define DMA_CHANNEL_CONSTS_VH
// Register byte offsets
`define OFS_SRC 8'h00
`define OFS_DST 8'h04
`define OFS_CNT 8'h08
`define OFS_BSZ 8'h0C
`define OFS_OFFS 8'h10
`define OFS_MODE 8'h14
`define OFS_REQSEL 8'h18
`define OFS_STAT 8'h1C
// Channel mode register fields
`define MD_EN 0
`define MD_END_STROBE_ENABLE 1
`define MD_SINGLE 2
`define MD_DIRS 3
`define MD_TRIG 5:4
`define MD_XMODE 7:6
`define MD_BURST 8
`define MD_SIZE 10:9
`define MD_BUSW 12:11
`define MD_DWIE 13
`define MD_SSTEP 15:14
`define MD_DSTEP 17:16
`define MD_ARS 18
`define MD_AREA_EN 19
`define MD_SWIN 24:20
`define MD_DWIN 29:25
`define MODE_MASK 32'h3FFF_FFFF
// Status register fields
`define ST_END_STATUS_FLAG 0
`define ST_BUSY 1
// Reset values
`define RST_WORD 32'h0000_0000
`define RST_BSZ 16'h0000
`define RST_SEL 8'h00
// Trigger kinds
`define TRIG_AUTO 2'h0
`define TRIG_PERIPH 2'h1
`define TRIG_EXT 2'h2
// Transfer modes
`define XM_NORMAL 2'h0
`define XM_REPEAT 2'h1
`define XM_BLOCK 2'h2
// Address step kinds
`define STEP_FIXED 2'h0
`define STEP_INC 2'h1
`define STEP_DEC 2'h2
`define STEP_OFFS 2'h3
// Window size codes: none, then 2^n bytes up to n = 27
`define WIN_NONE 5'h00
`define WIN_MAX 5'h1B
// Selector value meaning no source
`define SEL_NONE 8'h00
// Bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ===== rtl/window_addr_step.v
// Address update with optional power-of-two wrap window
`timescale 1ns/1ps
module window_addr_step (
	input wire [31:0] addr_i, // Current address
	input wire [31:0] delta_i, // Signed step, two's complement
	input wire [4:0] win_i, // Window size code
	output wire [31:0] next_o, // Updated address
	output wire wrap_o // Update left the window
);
`include "dma_channel_consts.vh"
	// Low bits that may change; all ones when no window or a prohibited code
	function [31:0] win_mask;
		input [4:0] w;
		begin
			if (w == `WIN_NONE || w > `WIN_MAX)
				win_mask = 32'hFFFF_FFFF;
			else
				win_mask = (32'h0000_0001 << w) - 32'h0000_0001;
		end
	endfunction
	wire [31:0] mask = win_mask(win_i);
	wire [31:0] full = addr_i + delta_i;
	// Upper bits held, low bits wrap modulo window
	assign next_o = (addr_i & ~mask) | (full & mask); // RULE1 RULE2 RULE18 RULE19
	assign wrap_o = ((full & ~mask) != (addr_i & ~mask)) && (mask != 32'hFFFF_FFFF);
endmodule // window_addr_step

// ===== rtl/request_source.v
// Transfer request source selection for one channel
`timescale 1ns/1ps
module request_source (
	input wire clk_i, // System clock
	input wire rst_n_i, // Asynchronous reset, active low
	input wire [1:0] trig_i, // Trigger kind
	input wire enable_i, // Channel enabled
	input wire [7:0] select_i, // Selected vector number
	input wire periph_valid_i, // Peripheral interrupt pulse
	input wire [7:0] periph_vector_i, // Its vector number
	input wire ext_req_n_i, // External request, active low
	input wire take_i, // Request accepted by channel
	output reg req_o // Request pending
);
`include "dma_channel_consts.vh"
	reg pend_r;
	wire hit = periph_valid_i && select_i != `SEL_NONE && periph_vector_i == select_i; // RULE3 RULE22
	// Peripheral request latched; a new one wins over the accept clear
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
			pend_r <= 1'b0;
		else if (hit)
			pend_r <= 1'b1;
		else if (take_i)
			pend_r <= 1'b0;
	end
	// Three trigger kinds
	always @*
	begin
		case (trig_i) // RULE8
			`TRIG_AUTO: req_o = enable_i;
			`TRIG_PERIPH: req_o = enable_i && pend_r;
			`TRIG_EXT: req_o = enable_i && !ext_req_n_i;
			default: req_o = 1'b0;
		endcase
	end
endmodule // request_source

// ===== verif/dma_channel_properties.sv
// Concurrent checks on the system-bus side of the DMA channel
`timescale 1ns/1ps
module dma_channel_properties (
	input wire clk_i, // Clock
	input wire rst_n_i, // Reset, active low
	input wire bus_req_o, // Bus request
	input wire bus_lock_o, // Bus lock
	input wire bus_cyc_o, // Cycle valid
	input wire bus_ack_i, // Cycle done
	input wire bus_we_o, // Write
	input wire [31:0] bus_addr_o, // Address
	input wire [2:0] bus_bytes_o, // Piece size
	input wire ack_strobe_n_o, // Acknowledge strobe
	input wire transfer_end_strobe_n_o // End strobe
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	read_first_a: assert property ($rose(bus_lock_o) |-> bus_cyc_o && !bus_we_o)
		else $error("locked pair does not open with a read");
	lock_release_a: assert property ($fell(bus_lock_o) |-> $past(bus_cyc_o && bus_we_o && bus_ack_i))
		else $error("bus lock dropped before the write finished");
	no_dual_ack_a: assert property (bus_lock_o |-> ack_strobe_n_o)
		else $error("acknowledge strobe during a dual transfer");
	ack_in_cycle_a: assert property (!ack_strobe_n_o |-> bus_cyc_o && !bus_lock_o)
		else $error("acknowledge strobe outside a single cycle");
	end_idle_a: assert property ($rose(bus_lock_o) && !transfer_end_strobe_n_o
		|-> $past(!transfer_end_strobe_n_o && bus_req_o))
		else $error("end strobe missing in the idle cycle");
	end_span_a: assert property (!transfer_end_strobe_n_o && bus_lock_o && !(bus_we_o && bus_ack_i)
		|=> !transfer_end_strobe_n_o && bus_lock_o)
		else $error("end strobe released inside the locked pair");
	cycle_hold_a: assert property (bus_cyc_o && !bus_ack_i
		|=> bus_cyc_o && $stable(bus_addr_o) && $stable(bus_we_o))
		else $error("bus cycle changed before its acknowledge");
	piece_size_a: assert property (bus_cyc_o |-> bus_bytes_o == 3'h1 || bus_bytes_o == 3'h2
		|| bus_bytes_o == 3'h4)
		else $error("illegal piece size");
endmodule // dma_channel_properties
bind dma_channel dma_channel_properties chk (.clk_i(clk_i), .rst_n_i(rst_n_i), .bus_req_o(bus_req_o),
	.bus_lock_o(bus_lock_o), .bus_cyc_o(bus_cyc_o), .bus_ack_i(bus_ack_i), .bus_we_o(bus_we_o),
	.bus_addr_o(bus_addr_o), .bus_bytes_o(bus_bytes_o), .ack_strobe_n_o(ack_strobe_n_o),
	.transfer_end_strobe_n_o(transfer_end_strobe_n_o));

// ===== verif/bus_memory_model.sv
// Behavioural system-bus memory with random stalls
`timescale 1ns/1ps
module bus_memory_model (
	input wire clk_i, // Clock
	input wire rst_n_i, // Reset, active low
	input wire stall_i, // Random wait
	input wire bus_req_i, // Request
	input wire bus_cyc_i, // Cycle valid
	input wire bus_we_i, // Write
	input wire [31:0] bus_addr_i, // Address
	input wire [31:0] bus_wdata_i, // Write data
	input wire [2:0] bus_bytes_i, // Piece size
	output reg bus_gnt_o, // Grant
	output reg bus_ack_o, // Cycle done
	output reg [31:0] bus_rdata_o // Read data
);
	reg [7:0] mem [0:255];
	wire [7:0] a = bus_addr_i[7:0];
	wire hit = bus_cyc_i && !bus_ack_o && !stall_i;
	integer k;
	// Known byte pattern
	initial
	begin
		for (k = 0; k < 256; k = k + 1)
			mem[k] = k[7:0] ^ 8'ha5;
	end
	// Grant, one acknowledge per cycle; read lines toggle except when answering a read
	always @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			bus_gnt_o <= 1'b0;
			bus_ack_o <= 1'b0;
			bus_rdata_o <= 32'h0000_0000;
		end
		else
		begin
			bus_gnt_o <= bus_req_i && !stall_i;
			bus_ack_o <= hit;
			bus_rdata_o <= ~bus_rdata_o;
			if (hit && bus_we_i)
				for (k = 0; k < bus_bytes_i; k = k + 1)
					mem[a + k[7:0]] <= bus_wdata_i[8 * k +: 8];
			else if (hit)
				bus_rdata_o <= {mem[a + 8'h03], mem[a + 8'h02], mem[a + 8'h01], mem[a]};
		end
	end
endmodule // bus_memory_model

// ===== verif/dma_channel_bench.sv
// Self-checking bench for one DMA channel
`timescale 1ns/1ps
`include "dma_channel_consts.vh"
module dma_channel_bench;
	reg clk_i, rst_n_i, awv, wv, arv, pv, ext_n, stall;
	reg [7:0] awa, ara, pvec;
	reg [31:0] wd, m, v;
	wire awr, wr, bv, arr, rv, req, gnt, lock, cyc, ack, we, ackn, endn;
	wire [1:0] bresp, rresp;
	wire [31:0] rd, ba, bwd, brd;
	wire [2:0] nb;
	integer failures, checked, seed, i, nack, nend, e0;
	reg [33:0] rq [$];
	reg [63:0] wq [$];
	reg [1:0] bq [$];
	dma_channel dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv),
		.s_axi_awready_o(awr), .s_axi_wdata_i(wd), .s_axi_wstrb_i(4'hf), .s_axi_wvalid_i(wv),
		.s_axi_wready_o(wr), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bv), .s_axi_bready_i(1'b1),
		.s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr), .s_axi_rdata_o(rd),
		.s_axi_rresp_o(rresp), .s_axi_rvalid_o(rv), .s_axi_rready_i(1'b1), .periph_irq_valid_i(pv),
		.periph_irq_vector_i(pvec), .ext_req_n_i(ext_n), .bus_req_o(req), .bus_gnt_i(gnt),
		.bus_lock_o(lock), .bus_cyc_o(cyc), .bus_ack_i(ack), .bus_we_o(we), .bus_addr_o(ba),
		.bus_bytes_o(nb), .bus_wdata_o(bwd), .bus_rdata_i(brd), .ack_strobe_n_o(ackn),
		.transfer_end_strobe_n_o(endn));
	bus_memory_model mem (.clk_i(clk_i), .rst_n_i(rst_n_i), .stall_i(stall), .bus_req_i(req),
		.bus_cyc_i(cyc), .bus_we_i(we), .bus_addr_i(ba), .bus_wdata_i(bwd), .bus_bytes_i(nb),
		.bus_gnt_o(gnt), .bus_ack_o(ack), .bus_rdata_o(brd));
	// Clock at 200 MHz
	initial
	begin
		clk_i = 1'b0;
		forever #2.5 clk_i = ~clk_i;
	end
	task check(input string nm, input [63:0] e, input [63:0] g);
	begin
		checked = checked + 1;
		if (e !== g)
		begin
			failures = failures + 1;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	end
	endtask
	task results;
	begin
		$display("checks %0d, mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	end
	endtask
	task axw(input [7:0] a, input [31:0] d);
		reg da, dw;
	begin
		bq.push_back((a <= `OFS_STAT && a[1:0] == 2'b00) ? `RESP_OKAY : `RESP_SLVERR);
		awa <= a;
		wd <= d;
		awv <= 1'b1;
		wv <= 1'b1;
		da = 0;
		dw = 0;
		while (!(da && dw))
		begin
			@(posedge clk_i);
			if (!da && awr)
			begin
				awv <= 1'b0;
				da = 1;
			end
			if (!dw && wr)
			begin
				wv <= 1'b0;
				dw = 1;
			end
		end
		while (!bv)
			@(posedge clk_i);
		@(posedge clk_i);
	end
	endtask
	task axr(input [7:0] a, input [33:0] e);
	begin
		rq.push_back(e);
		ara <= a;
		arv <= 1'b1;
		do
			@(posedge clk_i);
		while (!arr);
		arv <= 1'b0;
		while (!rv)
			@(posedge clk_i);
		@(posedge clk_i);
	end
	endtask
	task start(input [31:0] s, input [31:0] d, input [31:0] c, input [31:0] md);
	begin
		axw(`OFS_SRC, s);
		axw(`OFS_DST, d);
		axw(`OFS_CNT, c);
		axw(`OFS_MODE, md);
	end
	endtask
	task expw(input [31:0] a, input [31:0] d);
		wq.push_back({a, d});
	endtask
	task done(input string nm);
	begin
		while (wq.size() != 0 || req)
			@(posedge clk_i);
		repeat (20) @(posedge clk_i);
		check("pending writes", 0, wq.size());
		$display("test %s done", nm);
	end
	endtask
	// Random bus stalls
	always @(posedge clk_i)
		stall <= $random(seed) % 2 != 0;
	// Compares answers against the oldest note
	always @(posedge clk_i)
	begin
		if (!ackn)
			nack = nack + 1;
		if (!endn)
			nend = nend + 1;
		if (rv)
			check("register read", rq.size() ? rq.pop_front() : ~34'h0, {rresp, rd});
		if (bv)
			check("write response", bq.size() ? bq.pop_front() : 2'h3, bresp);
		if (cyc && ack && we && lock)
			check("bus write", wq.size() ? wq.pop_front() : ~64'h0, {ba, bwd & (nb == 3'h1 ? 32'h0000_00ff :
				nb == 3'h2 ? 32'h0000_ffff : 32'hffff_ffff)});
	end
	initial
	begin
		#200000;
		failures = failures + 1;
		results;
	end
	initial
	begin
		{rst_n_i, awv, wv, arv, pv, awa, ara, pvec, wd} = 0;
		ext_n = 1'b1;
		seed = 32'h268934ce;
		{failures, checked, nack, nend} = 0;
		repeat (2) @(posedge clk_i);
		rst_n_i <= 1'b1;
		@(posedge clk_i);
		axr(`OFS_MODE, {`RESP_OKAY, `RST_WORD});
		axr(`OFS_REQSEL, {`RESP_OKAY, 24'h0, `RST_SEL});
		v = $random(seed);
		axw(`OFS_REQSEL, v);
		axr(`OFS_REQSEL, {`RESP_OKAY, 24'h0, v[7:0]});
		axr(8'h20, {`RESP_SLVERR, 32'h0});
		axw(8'h20, v);
		$display("test registers done");
		for (i = 0; i < 3; i = i + 1)
		begin
			m = 32'h0401_5003 | (i << 6);
			axw(`OFS_BSZ, 32'h0000_0003);
			expw(32'h93, 8'ha5);
			expw(32'h90, 8'ha4);
			expw(32'h91, 8'ha7);
			start(0, 32'h93, 3, m);
			done("wrap increment");
			axr(`OFS_CNT, {`RESP_OKAY, 32'h0});
			axr(`OFS_MODE, {`RESP_OKAY, m & ~32'h1});
		end
		check("end strobe seen", 1, nend != 0);
		e0 = nend;
		m = 32'h0202_7001;
		expw(32'ha0, 8'ha5);
		start(0, 32'ha0, 4, m);
		done("wrap stop");
		axr(`OFS_STAT, {`RESP_OKAY, 32'h1});
		axr(`OFS_MODE, {`RESP_OKAY, m & ~32'h1});
		expw(32'ha1, 8'ha4);
		expw(32'ha0, 8'ha7);
		axw(`OFS_MODE, m);
		done("wrap resume");
		axw(`OFS_STAT, 32'h1);
		axr(`OFS_STAT, {`RESP_OKAY, 32'h0});
		check("end strobe disabled", e0, nend);
		axw(`OFS_REQSEL, 32'h42);
		start(0, 32'hb0, 1, 32'h0001_5011);
		@(posedge clk_i) {pv, pvec} <= {1'b1, 8'h41};
		@(posedge clk_i) pv <= 1'b0;
		done("wrong vector");
		expw(32'hb0, 8'ha5);
		@(posedge clk_i) {pv, pvec} <= {1'b1, 8'h42};
		@(posedge clk_i) pv <= 1'b0;
		done("peripheral request");
		expw(32'hb8, 8'ha0);
		start(5, 32'hb8, 1, 32'h0001_5021);
		ext_n <= 1'b0;
		done("external request");
		ext_n <= 1'b1;
		expw(32'hc0, 16'he4e5);
		expw(32'hc2, 16'he6e7);
		start(32'h40, 32'hc0, 4, 32'h0001_4c03);
		done("longword split");
		check("dual acknowledge", 0, nack);
		start(32'h10, 0, 1, 32'h0000_5005);
		done("single address");
		check("single acknowledge", 1, nack != 0);
		results;
	end
endmodule // dma_channel_bench
